// [include/modbus_dec_cfg.svh]
// Constants for the request address decoder: codes, bases, spans, slots
`ifndef MODBUS_DEC_CFG_SVH
`define MODBUS_DEC_CFG_SVH

// ----------------------------------------
// Function codes
// ----------------------------------------
`define FC_RD_OUT 8'h01
`define FC_RD_IN 8'h02
`define FC_RD_HOLD 8'h03
`define FC_RD_INREG 8'h04
`define FC_WR_OUT 8'h05
`define FC_WR_HOLD 8'h06
`define FC_DIAG 8'h08
`define FC_WRM_OUT 8'h0f
`define FC_WRM_HOLD 8'h10

// ----------------------------------------
// Exception codes
// ----------------------------------------
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02

// ----------------------------------------
// Input-bit region bases, direct addressing
// ----------------------------------------
`define DIR_BYTE_BASE 17'h00400
`define DIR_STAT_BASE 17'h00800
`define DIR_WORD_BASE 17'h01400

// ----------------------------------------
// Reference-number input-bit bases
// ----------------------------------------
`define REF_ALLOC_BASE 17'h02711
`define REF_BYTE_BASE 17'h032c9
`define REF_STAT_BASE 17'h036b1
`define REF_WORD_BASE 17'h03e81
// Same bases relative to the allocated base
`define REFO_BYTE 17'h00bb8
`define REFO_STAT 17'h00fa0
`define REFO_WORD 17'h01770

// ----------------------------------------
// Reference-number ranges
// ----------------------------------------
`define REF_OUT_LAST 16'h270f
`define REF_IN_FIRST 16'h2710
`define REF_IN_LAST 16'h4e1f
`define REF_INREG_FIRST 16'h7530
`define REF_INREG_LAST 16'h9c3f
`define REF_HOLD_FIRST 16'h9c40
`define REF_HOLD_LAST 16'hc34f

// ----------------------------------------
// Region spans in bits and slot numbers
// ----------------------------------------
`define BYTE_SPAN 17'h001a0
`define STAT_SPAN 17'h00198
`define WORD_SPAN 17'h00310
`define SLOT_COM_LO 6'h00
`define SLOT_COM_HI 6'h31
`define SLOT_PSU 6'h32
`define SLOT_IO_FIRST 6'h01
`define SLOT_IO_LAST 6'h30
`define BIT_HALF 5'h04
`define BYTE_BITS 5'h08
`define WORD_BITS 5'h10
`define ALLOC_BITS_DEF 1024

`endif

// [include/modbus_dec_pkg.sv]
// Types and shared slot decoding for the request address decoder
`default_nettype none
`include "modbus_dec_cfg.svh"

package modbus_dec_pkg;

  typedef enum logic [2:0] {SP_NONE, SP_IN_BIT, SP_OUT_BIT, SP_IN_REG, SP_HOLD_REG} space_e;
  typedef enum logic [2:0] {RG_FLAT, RG_ALLOC, RG_BYTE_SLOT, RG_STATUS, RG_WORD_SLOT} region_e;
  typedef enum logic [1:0] {SC_COM, SC_IO, SC_PSU, SC_BAD} slot_class_e;

  // Slot ownership: com units at 0 and 49, supply last at 50, modules between
  function automatic slot_class_e slot_class(input logic [5:0] s);
    if (s == `SLOT_COM_LO || s == `SLOT_COM_HI) begin
      return SC_COM;
    end else if (s == `SLOT_PSU) begin
      return SC_PSU;
    end else if (s >= `SLOT_IO_FIRST && s <= `SLOT_IO_LAST) begin
      return SC_IO;
    end else begin
      return SC_BAD;
    end
  endfunction

endpackage

`default_nettype wire

// [rtl/slot_addr_calc.sv]
// Slot and bit to Modbus address calculator for the input-bit regions
`timescale 1ns/1ps
`default_nettype none
`include "modbus_dec_cfg.svh"

module slot_addr_calc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic calc_valid,
  input wire logic calc_ref_mode,
  input wire modbus_dec_pkg::region_e calc_region,
  input wire logic [5:0] calc_slot,
  input wire logic [4:0] calc_bit,
  output logic calc_done,
  output logic [15:0] calc_addr,
  output logic calc_err
);
  import modbus_dec_pkg::*;

  logic done_r, done_nxt, err_r, err_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [16:0] base, term, sum;
  logic ok;

  // ----------------------------------------
  // Address formula
  // ----------------------------------------
  // Channels 5..8 spill into the next slot's byte, hence slot+1
  always_comb begin
    base = 17'h00000;
    term = 17'h00000;
    ok = 1'b0;
    case (calc_region)
      RG_BYTE_SLOT: begin
        base = calc_ref_mode ? `REF_BYTE_BASE : `DIR_BYTE_BASE;
        term = (calc_bit <= `BIT_HALF) ? 17'({calc_slot, 3'b000})
             : 17'({7'({1'b0, calc_slot} + 7'h01), 3'b000});
        ok = calc_slot <= `SLOT_PSU && calc_bit >= 5'h01 && calc_bit <= `BYTE_BITS;
      end
      RG_STATUS: begin
        base = calc_ref_mode ? `REF_STAT_BASE : `DIR_STAT_BASE;
        term = 17'({calc_slot, 3'b000});
        ok = calc_slot <= `SLOT_PSU && calc_bit >= 5'h01 && calc_bit <= `BYTE_BITS;
      end
      RG_WORD_SLOT: begin
        base = calc_ref_mode ? `REF_WORD_BASE : `DIR_WORD_BASE;
        term = 17'({calc_slot, 4'b0000});
        ok = slot_class(calc_slot) == SC_IO && calc_bit >= 5'h01
          && calc_bit <= `WORD_BITS;
      end
      default: begin
        ok = 1'b0; // Allocated and flat spaces have no slot formula, so they are refused
      end
    endcase
    sum = base + term + 17'(calc_bit) - 17'h00001;
    done_nxt = calc_valid;
    err_nxt = calc_valid ? !ok : err_r;
    addr_nxt = (calc_valid && ok) ? sum[15:0] : addr_r;
  end

  // Result registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      addr_r <= 16'h0000;
    end else begin
      done_r <= done_nxt;
      err_r <= err_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign calc_done = done_r;
  assign calc_err = err_r;
  assign calc_addr = addr_r;

endmodule

`default_nettype wire

// [rtl/modbus_address_decoder.sv]
// Modbus request address decoder for a remote I/O station
`timescale 1ns/1ps
`default_nettype none
`include "modbus_dec_cfg.svh"

module modbus_address_decoder #(
  parameter int ALLOC_BITS = `ALLOC_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ref_mode,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  output logic resp_valid,
  output logic resp_exc,
  output logic [7:0] resp_exc_code,
  output var modbus_dec_pkg::space_e resp_space,
  output var modbus_dec_pkg::region_e resp_region,
  output logic resp_write,
  output logic resp_multi,
  output logic [15:0] resp_index,
  output logic [5:0] resp_slot,
  output var modbus_dec_pkg::slot_class_e resp_slot_class,
  output logic [4:0] resp_bit,
  input wire logic calc_valid,
  input wire logic calc_ref_mode,
  input wire modbus_dec_pkg::region_e calc_region,
  input wire logic [5:0] calc_slot,
  input wire logic [4:0] calc_bit,
  output logic calc_done,
  output logic [15:0] calc_addr,
  output logic calc_err
);
  import modbus_dec_pkg::*;

  typedef struct packed {
    logic hit;
    region_e region;
    logic [15:0] index;
    logic [5:0] slot;
    logic [4:0] bitn;
  } in_dec_s;

  // ----------------------------------------
  // Input-bit region decoding
  // ----------------------------------------
  // Offset o is relative to the allocated region's start; the other bases
  // differ between the two addressing schemes, so they come in as arguments.
  function automatic in_dec_s decode_in(input logic [16:0] o, input logic [16:0] b8,
                                         input logic [16:0] bst, input logic [16:0] b16);
    in_dec_s d;
    logic [16:0] r;
    logic [5:0] s;
    d.hit = 1'b0;
    d.region = RG_FLAT;
    d.index = 16'h0000;
    d.slot = 6'h00;
    d.bitn = 5'h00;
    r = 17'h00000;
    s = 6'h00;
    if (o < 17'(ALLOC_BITS)) begin
      d.hit = 1'b1;
      d.region = RG_ALLOC;
      d.index = o[15:0];
    end else if (o >= b8 && o < b8 + `BYTE_SPAN) begin
      r = o - b8;
      s = r[8:3];
      // Channels 5..8 sit in the next byte, so that byte belongs to slot-1
      if (r[2]) begin
        s = s - 6'h01;
      end
      d.hit = (r[8:3] != 6'h00 || !r[2]) && s <= `SLOT_PSU;
      d.region = RG_BYTE_SLOT;
      d.index = r[15:0];
      d.slot = s;
      d.bitn = {2'b00, r[2:0]} + 5'h01;
    end else if (o >= bst && o < bst + `STAT_SPAN) begin
      r = o - bst;
      d.hit = 1'b1;
      d.region = RG_STATUS;
      d.index = r[15:0];
      d.slot = r[8:3];
      d.bitn = {2'b00, r[2:0]} + 5'h01;
    end else if (o >= b16 && o < b16 + `WORD_SPAN) begin
      r = o - b16;
      d.hit = slot_class(r[9:4]) == SC_IO;
      d.region = RG_WORD_SLOT;
      d.index = r[15:0];
      d.slot = r[9:4];
      d.bitn = {1'b0, r[3:0]} + 5'h01;
    end
    return d;
  endfunction

  // ----------------------------------------
  // Response register group
  // ----------------------------------------
  logic valid_r, valid_nxt, exc_r, exc_nxt, wr_r, wr_nxt, multi_r, multi_nxt;
  logic [7:0] code_r, code_nxt;
  space_e space_r, space_nxt;
  region_e region_r, region_nxt;
  logic [15:0] index_r, index_nxt;
  logic [5:0] slot_r, slot_nxt;
  logic [4:0] bit_r, bit_nxt;
  slot_class_e cls_r, cls_nxt;
  in_dec_s dec_dir, dec_ref, dec;
  logic [16:0] ref_off;

  // Both schemes go through the same input-bit decoder, only rebased
  assign ref_off = {1'b0, req_addr} - `REF_ALLOC_BASE;
  assign dec_dir = decode_in({1'b0, req_addr}, `DIR_BYTE_BASE, `DIR_STAT_BASE,
                             `DIR_WORD_BASE);
  assign dec_ref = decode_in(ref_off, `REFO_BYTE, `REFO_STAT, `REFO_WORD);

  // Next answer; a decode is taken each cycle req_valid is high
  always_comb begin
    valid_nxt = req_valid;
    exc_nxt = 1'b0;
    code_nxt = 8'h00;
    space_nxt = SP_NONE;
    region_nxt = RG_FLAT;
    wr_nxt = 1'b0;
    multi_nxt = 1'b0;
    index_nxt = req_addr;
    slot_nxt = 6'h00;
    bit_nxt = 5'h00;
    dec = dec_dir;
    if (!req_ref_mode) begin
      case (req_func)
        `FC_RD_IN: space_nxt = SP_IN_BIT;
        `FC_RD_OUT: space_nxt = SP_OUT_BIT;
        `FC_RD_INREG: space_nxt = SP_IN_REG;
        `FC_RD_HOLD: space_nxt = SP_HOLD_REG;
        `FC_WR_OUT, `FC_WRM_OUT: begin
          space_nxt = SP_OUT_BIT;
          wr_nxt = 1'b1;
          multi_nxt = req_func == `FC_WRM_OUT;
        end
        `FC_WR_HOLD, `FC_WRM_HOLD: begin
          space_nxt = SP_HOLD_REG;
          wr_nxt = 1'b1;
          multi_nxt = req_func == `FC_WRM_HOLD;
        end
        `FC_DIAG: space_nxt = SP_NONE; // Diagnostics touch no data space
        default: begin
          exc_nxt = 1'b1;
          code_nxt = `EXC_ILL_FUNC;
        end
      endcase
    end else begin
      // Space comes from the number range; the code only says read or write
      dec = dec_ref;
      if (req_addr <= `REF_OUT_LAST) begin
        space_nxt = SP_OUT_BIT;
      end else if (req_addr >= `REF_IN_FIRST && req_addr <= `REF_IN_LAST) begin
        space_nxt = SP_IN_BIT;
      end else if (req_addr >= `REF_INREG_FIRST && req_addr <= `REF_INREG_LAST) begin
        space_nxt = SP_IN_REG;
        index_nxt = req_addr - `REF_INREG_FIRST;
      end else if (req_addr >= `REF_HOLD_FIRST && req_addr <= `REF_HOLD_LAST) begin
        space_nxt = SP_HOLD_REG;
        index_nxt = req_addr - `REF_HOLD_FIRST;
      end else begin
        exc_nxt = 1'b1;
        code_nxt = `EXC_ILL_ADDR;
      end
      case (req_func)
        `FC_WR_OUT, `FC_WRM_OUT: begin
          wr_nxt = 1'b1;
          multi_nxt = req_func == `FC_WRM_OUT;
          if (!exc_nxt && space_nxt != SP_OUT_BIT) begin
            exc_nxt = 1'b1;
            code_nxt = `EXC_ILL_FUNC;
          end
        end
        `FC_WR_HOLD, `FC_WRM_HOLD: begin
          wr_nxt = 1'b1;
          multi_nxt = req_func == `FC_WRM_HOLD;
          if (!exc_nxt && space_nxt != SP_HOLD_REG) begin
            exc_nxt = 1'b1;
            code_nxt = `EXC_ILL_FUNC;
          end
        end
        default: wr_nxt = 1'b0;
      endcase
    end
    // Input bits map through the region table; holes are address errors
    if (!exc_nxt && space_nxt == SP_IN_BIT) begin
      region_nxt = dec.region;
      index_nxt = dec.index;
      slot_nxt = dec.slot;
      bit_nxt = dec.bitn;
      if (!dec.hit) begin
        exc_nxt = 1'b1;
        code_nxt = `EXC_ILL_ADDR;
      end
    end
    // An exception answer names no space
    if (exc_nxt) begin
      space_nxt = SP_NONE;
      wr_nxt = 1'b0;
      multi_nxt = 1'b0;
    end
    // Class is registered so the output comes straight from a flop
    cls_nxt = slot_class(slot_nxt);
  end

  // Answer registers, valid for one cycle per request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      exc_r <= 1'b0;
      code_r <= 8'h00;
      space_r <= SP_NONE;
      region_r <= RG_FLAT;
      wr_r <= 1'b0;
      multi_r <= 1'b0;
      index_r <= 16'h0000;
      slot_r <= 6'h00;
      bit_r <= 5'h00;
      cls_r <= SC_COM;
    end else begin
      valid_r <= valid_nxt;
      exc_r <= exc_nxt;
      code_r <= code_nxt;
      space_r <= space_nxt;
      region_r <= region_nxt;
      wr_r <= wr_nxt;
      multi_r <= multi_nxt;
      index_r <= index_nxt;
      slot_r <= slot_nxt;
      bit_r <= bit_nxt;
      cls_r <= cls_nxt;
    end
  end

  assign resp_valid = valid_r;
  assign resp_exc = exc_r;
  assign resp_exc_code = code_r;
  assign resp_space = space_r;
  assign resp_region = region_r;
  assign resp_write = wr_r;
  assign resp_multi = multi_r;
  assign resp_index = index_r;
  assign resp_slot = slot_r;
  assign resp_slot_class = cls_r;
  assign resp_bit = bit_r;

  // ----------------------------------------
  // Slot formula calculator for the master side
  // ----------------------------------------
  // Lets the master look up an address from slot and bit instead of
  // hard-coding the region formulas
  slot_addr_calc u_calc (
    .clk(clk),
    .rst_n(rst_n),
    .calc_valid(calc_valid),
    .calc_ref_mode(calc_ref_mode),
    .calc_region(calc_region),
    .calc_slot(calc_slot),
    .calc_bit(calc_bit),
    .calc_done(calc_done),
    .calc_addr(calc_addr),
    .calc_err(calc_err)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_direct(logic [7:0] f);
    req_valid && !req_ref_mode && req_func == f;
  endsequence

  sequence s_ref_in(logic [15:0] lo, logic [15:0] hi);
    req_valid && req_ref_mode && req_addr >= lo && req_addr <= hi;
  endsequence

  chk_read_in_space: assert property (s_direct(`FC_RD_IN) |=> resp_valid
    && (resp_exc || resp_space == SP_IN_BIT)) else $error("input read wrong space");
  chk_single_write: assert property (s_direct(`FC_WR_OUT) |=> resp_write
    && !resp_multi && resp_space == SP_OUT_BIT) else $error("single coil write wrong");
  chk_multi_write: assert property (s_direct(`FC_WRM_HOLD) |=> resp_write
    && resp_multi && resp_space == SP_HOLD_REG) else $error("multi register write wrong");
  chk_flat_index: assert property (s_direct(`FC_RD_INREG) |=> !resp_exc
    && resp_index == $past(req_addr)) else $error("flat index wrong");
  chk_ref_hold: assert property (s_ref_in(`REF_HOLD_FIRST, `REF_HOLD_LAST)
    ##0 req_func == `FC_RD_IN |=> resp_space == SP_HOLD_REG
    && resp_index == $past(req_addr) - `REF_HOLD_FIRST) else $error("ref holding wrong");
  chk_word_slot_io: assert property (resp_valid && !resp_exc
    && resp_region == RG_WORD_SLOT |-> resp_slot_class == SC_IO) else $error("word slot bad");
  chk_alloc_window: assert property (s_direct(`FC_RD_IN) ##0 req_addr < 16'(ALLOC_BITS)
    |=> resp_region == RG_ALLOC && resp_index == $past(req_addr)) else $error("alloc bad");
  chk_status_bits: assert property (resp_valid && !resp_exc && resp_region == RG_STATUS
    |-> resp_bit >= 5'h01 && resp_bit <= `BYTE_BITS) else $error("status bit range bad");
  chk_ref_status: assert property (s_ref_in(16'(`REF_STAT_BASE), 16'h3848)
    |=> resp_exc ? resp_exc_code == `EXC_ILL_FUNC : resp_region == RG_STATUS)
    else $error("ref status region bad");
  chk_bad_func: assert property (req_valid && !req_ref_mode && req_func == 8'h07
    |=> resp_exc && resp_exc_code == `EXC_ILL_FUNC && resp_space == SP_NONE)
    else $error("unknown code not refused");
  chk_calc_done: assert property (calc_valid ##1 1'b1 |-> calc_done
    ##1 (calc_done == $past(calc_valid))) else $error("calc latency wrong");

endmodule

`default_nettype wire

// [testbench/modbus_master_model.sv]
// Polling master model that issues decode requests to the address decoder
`timescale 1ns/1ps
`default_nettype none

module modbus_master_model (
  input wire logic clk,
  output logic req_valid,
  output logic req_ref_mode,
  output logic [7:0] req_func,
  output logic [15:0] req_addr
);
  import modbus_dec_pkg::*;

  // Quiet bus at start
  initial begin
    req_valid = 1'b0;
    req_ref_mode = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
  end

  // One request held across exactly one rising edge; released lines show the
  // inverse so a decoder that samples late never sees a stale good copy
  task automatic send(input logic rm, input logic [7:0] fc, input logic [15:0] ad);
    @(negedge clk);
    req_valid = 1'b1;
    req_ref_mode = rm;
    req_func = fc;
    req_addr = ad;
    @(negedge clk);
    req_valid = 1'b0;
    req_ref_mode = ~rm;
    req_func = ~fc;
    req_addr = ~ad;
  endtask

  // Address of a slot item: slot and bit put into the region's formula
  function automatic logic [15:0] slot_address(input logic rm, input region_e rg,
      input int slot, input int bitn);
    int base;
    int s;
    s = slot;
    case (rg)
      RG_BYTE_SLOT: base = rm ? 13001 : 1024;
      RG_STATUS: base = rm ? 14001 : 2048;
      default: base = rm ? 16001 : 5120;
    endcase
    if (rg == RG_BYTE_SLOT && bitn > 4) begin
      s = slot + 1;
    end
    return 16'(base + (rg == RG_WORD_SLOT ? 16 : 8) * s + bitn - 1);
  endfunction
endmodule

`default_nettype wire

// [testbench/tb.sv]
// Self-checking testbench for the request address decoder
`timescale 1ns/1ps
`default_nettype none

module tb;
  import modbus_dec_pkg::*;

  logic clk, rst_n, req_valid, req_ref_mode, resp_valid, resp_exc, resp_write, resp_multi;
  logic [7:0] req_func, resp_exc_code;
  logic [15:0] req_addr, resp_index, calc_addr;
  logic [5:0] resp_slot, calc_slot;
  logic [4:0] resp_bit, calc_bit;
  logic calc_valid, calc_ref_mode, calc_done, calc_err;
  space_e resp_space;
  region_e resp_region, calc_region;
  slot_class_e resp_slot_class;
  int failures = 0;
  int samples_checked = 0;

  modbus_address_decoder dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ref_mode(req_ref_mode), .req_func(req_func), .req_addr(req_addr),
    .resp_valid(resp_valid), .resp_exc(resp_exc), .resp_exc_code(resp_exc_code),
    .resp_space(resp_space), .resp_region(resp_region), .resp_write(resp_write),
    .resp_multi(resp_multi), .resp_index(resp_index), .resp_slot(resp_slot),
    .resp_slot_class(resp_slot_class), .resp_bit(resp_bit), .calc_valid(calc_valid),
    .calc_ref_mode(calc_ref_mode), .calc_region(calc_region), .calc_slot(calc_slot),
    .calc_bit(calc_bit), .calc_done(calc_done), .calc_addr(calc_addr), .calc_err(calc_err));

  modbus_master_model master (.clk(clk), .req_valid(req_valid), .req_ref_mode(req_ref_mode),
    .req_func(req_func), .req_addr(req_addr));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Shared checking tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Decode one request; write flags are worked out here from the code
  task automatic decode(input logic rm, input logic [7:0] fc, input logic [15:0] ad,
      input logic [7:0] xc, input space_e sp, input region_e rg, input logic [15:0] ix,
      input logic [5:0] sl, input logic [4:0] bt);
    int n;
    logic wr;
    n = 0;
    wr = (fc == 8'h05 || fc == 8'h06 || fc == 8'h0f || fc == 8'h10);
    master.send(rm, fc, ad);
    while (resp_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check("resp_valid", 16'h0001, {15'h0, resp_valid});
    check("exc_code", {8'h0, xc}, {8'h0, resp_exc_code});
    check("exc", {15'h0, xc != 8'h00}, {15'h0, resp_exc});
    if (xc == 8'h00) begin
      check("space", {13'h0, sp}, {13'h0, resp_space});
      check("region", {13'h0, rg}, {13'h0, resp_region});
      check("index", ix, resp_index);
      check("slot", {10'h0, sl}, {10'h0, resp_slot});
      check("bit", {11'h0, bt}, {11'h0, resp_bit});
      check("write", {15'h0, wr}, {15'h0, resp_write});
      check("multi", {15'h0, fc == 8'h0f || fc == 8'h10}, {15'h0, resp_multi});
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every code in direct mode at address 0, an unknown code and the top address
  task automatic t_codes();
    logic [7:0] fc [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h08};
    space_e sp [9] = '{SP_OUT_BIT, SP_IN_BIT, SP_HOLD_REG, SP_IN_REG, SP_OUT_BIT,
      SP_HOLD_REG, SP_OUT_BIT, SP_HOLD_REG, SP_NONE};
    for (int i = 0; i < 9; i++) begin
      decode(1'b0, fc[i], 16'h0000, 8'h00, sp[i], (sp[i] == SP_IN_BIT) ? RG_ALLOC : RG_FLAT,
        16'h0000, 6'h00, 5'h00);
    end
    decode(1'b0, 8'h07, 16'h0000, 8'h01, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b0, 8'h03, 16'hffff, 8'h00, SP_HOLD_REG, RG_FLAT, 16'hffff, 6'h0, 5'h0);
    decode(1'b0, 8'h04, 16'hffff, 8'h00, SP_IN_REG, RG_FLAT, 16'hffff, 6'h0, 5'h0);
    $display("test codes done");
  endtask

  // Reference numbers: range edges, holes and writes to the wrong space
  task automatic t_ref();
    decode(1'b1, 8'h01, 16'd9999, 8'h00, SP_OUT_BIT, RG_FLAT, 16'd9999, 6'h0, 5'h0);
    decode(1'b1, 8'h03, 16'd10001, 8'h00, SP_IN_BIT, RG_ALLOC, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h02, 16'd30000, 8'h00, SP_IN_REG, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h04, 16'd49999, 8'h00, SP_HOLD_REG, RG_FLAT, 16'd9999, 6'h0, 5'h0);
    decode(1'b1, 8'h03, 16'd20000, 8'h02, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h03, 16'd50000, 8'h02, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h06, 16'd40000, 8'h00, SP_HOLD_REG, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h05, 16'd10001, 8'h01, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h10, 16'd30000, 8'h01, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b1, 8'h0f, 16'd0, 8'h00, SP_OUT_BIT, RG_FLAT, 16'h0, 6'h0, 5'h0);
    $display("test reference done");
  endtask

  // Slot regions in both schemes at slot and bit boundaries, plus gaps
  task automatic t_regions();
    region_e rg [7] = '{RG_BYTE_SLOT, RG_BYTE_SLOT, RG_BYTE_SLOT, RG_STATUS, RG_STATUS,
      RG_WORD_SLOT, RG_WORD_SLOT};
    int sl [7] = '{0, 3, 50, 49, 50, 48, 1};
    int bt [7] = '{5, 3, 8, 8, 1, 16, 1};
    slot_class_e cl [7] = '{SC_COM, SC_IO, SC_PSU, SC_COM, SC_PSU, SC_IO, SC_IO};
    logic [15:0] a;
    logic [15:0] b;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 7; i++) begin
        a = master.slot_address(m[0], rg[i], sl[i], bt[i]);
        b = master.slot_address(m[0], rg[i], 0, 1);
        decode(m[0], 8'h02, a, 8'h00, SP_IN_BIT, rg[i], a - b,
          6'(sl[i]), 5'(bt[i]));
        check("slot class", {14'h0, cl[i]}, {14'h0, resp_slot_class});
      end
    end
    decode(1'b0, 8'h02, 16'd1028, 8'h02, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b0, 8'h02, 16'd5120, 8'h02, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    decode(1'b0, 8'h02, 16'd2456, 8'h02, SP_NONE, RG_FLAT, 16'h0, 6'h0, 5'h0);
    $display("test regions done");
  endtask

  // One calculator request; a refused one must leave the address alone
  task automatic calc(input logic rm, input region_e rg, input logic [5:0] sl,
      input logic [4:0] bt, input logic er);
    logic [15:0] prev;
    int n;
    prev = calc_addr;
    n = 0;
    @(negedge clk);
    calc_valid = 1'b1;
    calc_ref_mode = rm;
    calc_region = rg;
    calc_slot = sl;
    calc_bit = bt;
    @(negedge clk);
    calc_valid = 1'b0;
    while (calc_done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check("calc_done", 16'h0001, {15'h0, calc_done});
    check("calc_err", {15'h0, er}, {15'h0, calc_err});
    check("calc_addr", er ? prev : master.slot_address(rm, rg, int'(sl), int'(bt)),
      calc_addr);
  endtask

  task automatic t_calc();
    calc(1'b0, RG_BYTE_SLOT, 6'd3, 5'd6, 1'b0);
    calc(1'b1, RG_STATUS, 6'd50, 5'd8, 1'b0);
    calc(1'b1, RG_WORD_SLOT, 6'd48, 5'd16, 1'b0);
    calc(1'b0, RG_WORD_SLOT, 6'd0, 5'd1, 1'b1);
    calc(1'b0, RG_BYTE_SLOT, 6'd51, 5'd1, 1'b1);
    calc(1'b0, RG_STATUS, 6'd2, 5'd9, 1'b1);
    calc(1'b0, RG_ALLOC, 6'd1, 5'd1, 1'b1);
    $display("test calculator done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs about a hundred cycles; cut off well beyond that
  initial begin
    #(8 * 20000);
    failures++;
    finish_test();
  end

  // Reset for six cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    calc_valid = 1'b0;
    calc_ref_mode = 1'b0;
    calc_region = RG_FLAT;
    calc_slot = 6'h00;
    calc_bit = 5'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_codes();
    t_ref();
    t_regions();
    t_calc();
    finish_test();
  end
endmodule

`default_nettype wire
